// File: rtl/esrb_builder.v
// element status report builder: header, sorted descriptors, padding
`timescale 1ns/1ps
`default_nettype none
`include "esrb_defs.vh"
module esrb_builder #(
  parameter NUM_ELEM   = 8,
  parameter FIFO_DEPTH = 8,
  parameter PCW        = 16,
  parameter [3:0] SENSE_KEY_ILLEGAL = 4'h5,
  parameter [7:0] ASC_INVALID_FIELD = 8'h24
) (
  input  wire                   ref_clk_in,
  input  wire                   rst_in,
  input  wire                   cmd_start_in,
  input  wire [1:0]             cmd_filter_in,
  input  wire [31:0]            cmd_start_elem_in,
  input  wire [PCW-1:0]         cmd_page_count_in,
  input  wire [31:0]            depop_id_in,
  input  wire [NUM_ELEM-1:0]    elem_valid_in,
  input  wire [32*NUM_ELEM-1:0] elem_id_in,
  input  wire [8*NUM_ELEM-1:0]  elem_health_in,
  input  wire [NUM_ELEM-1:0]    elem_restore_in,
  input  wire [64*NUM_ELEM-1:0] elem_cap_in,
  input  wire [NUM_ELEM-1:0]    elem_cap_known_in,
  input  wire                   crc_fail_in,
  output wire [7:0]             data_out,
  output wire                   data_valid_out,
  input  wire                   data_ready_in,
  output wire                   busy_out,
  output reg                    done_out,
  output reg  [7:0]             error_out,
  output reg  [7:0]             status_out,
  output reg  [3:0]             sense_key_out,
  output reg  [7:0]             asc_out
);
  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_CALC = 6'h02;
  localparam [5:0] ST_HDR  = 6'h04;
  localparam [5:0] ST_DESC = 6'h08;
  localparam [5:0] ST_PAD  = 6'h10;
  localparam [5:0] ST_DONE = 6'h20;
  localparam       BW      = PCW + `ESRB_PAGE_SHIFT;

  // health filter: out of limit or any depopulation outcome
  function filt_ok;
    input [7:0] h;
    begin
      filt_ok = (h >= `ESRB_HLTH_OUT_LO && h <= `ESRB_HLTH_OUT_HI) ||
                (h >= `ESRB_HLTH_REV_FAIL);
    end
  endfunction

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [5:0]     state_q;
  reg [1:0]     filter_q;
  reg [31:0]    start_q;
  reg [PCW-1:0] pages_q;
  reg [31:0]    total_q;
  reg [31:0]    ret_q;
  reg [31:0]    depop_q;
  reg [31:0]    left_q;
  reg [BW-1:0]  byte_q;
  reg           first_q;
  reg [31:0]    last_q;
  reg [31:0]    cur_id_q;
  reg [7:0]     cur_hlth_q;
  reg           cur_rest_q;
  reg [63:0]    cur_cap_q;
  reg           cur_capk_q;
  reg           abort_q;
  reg           crc_q;

  // ------------------------------------------------------------
  // element qualification and ascending pick
  // ------------------------------------------------------------
  reg [NUM_ELEM-1:0] qual;
  reg [31:0]         total_cnt;
  reg                any_at_start;
  reg                best_found;
  reg [31:0]         best_id;
  reg [31:0]         best_idx;
  reg [31:0]         eid;
  integer            i;

  always @* begin
    total_cnt    = 32'h00000000;
    any_at_start = 1'b0;
    best_found   = 1'b0;
    best_id      = 32'h00000000;
    best_idx     = 32'h00000000;
    eid          = 32'h00000000;
    for (i = 0; i < NUM_ELEM; i = i + 1) begin
      eid = elem_id_in[32*i +: 32];
      qual[i] = elem_valid_in[i] && (eid >= start_q) &&
                (filter_q != `ESRB_FILTER_HEALTH ||
                 filt_ok(elem_health_in[8*i +: 8]));
      if (elem_valid_in[i] && eid >= start_q) begin
        any_at_start = 1'b1;
      end
      total_cnt = total_cnt + {31'h00000000, qual[i]};
      // smallest id above the last one sent keeps the list sorted
      if (qual[i] && (first_q || eid > last_q) &&
          (!best_found || eid < best_id)) begin
        best_found = 1'b1;
        best_id    = eid;
        best_idx   = i;
      end
    end
  end

  // ------------------------------------------------------------
  // byte generation
  // ------------------------------------------------------------
  wire [4:0]   off;
  wire [7:0]   desc_byte;
  reg  [7:0]   hdr_byte;
  wire [31:0]  slots;
  wire [BW-1:0] last_byte;
  wire         fifo_ready;
  wire         pushing;
  wire         streaming;

  assign off       = byte_q[4:0];
  assign streaming = (state_q == ST_HDR) || (state_q == ST_DESC) ||
                     (state_q == ST_PAD);
  // header occupies one descriptor slot of the first page
  assign slots     = {{(32-PCW-4){1'b0}}, pages_q, 4'h0} - 32'h00000001;
  assign last_byte = {pages_q, {`ESRB_PAGE_SHIFT{1'b0}}} - 1'b1;
  assign pushing   = streaming & fifo_ready;
  assign busy_out  = (state_q != ST_IDLE);

  always @* begin
    hdr_byte = 8'h00;
    case (off[4:2])
      3'h0: hdr_byte = total_q[8*off[1:0] +: 8];
      3'h1: hdr_byte = ret_q[8*off[1:0] +: 8];
      3'h2: hdr_byte = depop_q[8*off[1:0] +: 8];
      default: hdr_byte = 8'h00;
    endcase
  end

  esrb_desc_byte u_desc (
    .off_in       (off),
    .id_in        (cur_id_q),
    .restore_in   (cur_rest_q),
    .health_in    (cur_hlth_q),
    .cap_in       (cur_cap_q),
    .cap_known_in (cur_capk_q),
    .byte_out     (desc_byte)
  );

  reg [7:0] push_byte;
  always @* begin
    case (state_q)
      ST_HDR:  push_byte = hdr_byte;
      ST_DESC: push_byte = desc_byte;
      default: push_byte = 8'h00;
    endcase
  end

  // the host side can stall; a full fifo holds the builder still
  esrb_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in    (ref_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (streaming),
    .in_ready_out  (fifo_ready),
    .in_data_in    (push_byte),
    .out_valid_out (data_valid_out),
    .out_ready_in  (data_ready_in),
    .out_data_out  (data_out)
  );

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q    <= ST_IDLE;
      filter_q   <= 2'h0;
      start_q    <= 32'h00000000;
      pages_q    <= {PCW{1'b0}};
      total_q    <= 32'h00000000;
      ret_q      <= 32'h00000000;
      depop_q    <= 32'h00000000;
      left_q     <= 32'h00000000;
      byte_q     <= {BW{1'b0}};
      first_q    <= 1'b1;
      last_q     <= 32'h00000000;
      cur_id_q   <= 32'h00000000;
      cur_hlth_q <= 8'h00;
      cur_rest_q <= 1'b0;
      cur_cap_q  <= 64'h0000000000000000;
      cur_capk_q <= 1'b0;
      abort_q    <= 1'b0;
      crc_q      <= 1'b0;
      done_out   <= 1'b0;
      error_out  <= 8'h00;
      status_out <= 8'h00;
      sense_key_out <= 4'h0;
      asc_out    <= 8'h00;
    end else begin
      done_out <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (cmd_start_in) begin
            filter_q   <= cmd_filter_in;
            start_q    <= cmd_start_elem_in;
            pages_q    <= cmd_page_count_in;
            first_q    <= 1'b1;
            byte_q     <= {BW{1'b0}};
            abort_q    <= 1'b0;
            crc_q      <= 1'b0;
            error_out  <= 8'h00;
            status_out <= 8'h00;
            sense_key_out <= 4'h0;
            asc_out    <= 8'h00;
            state_q    <= ST_CALC;
          end
        end
        ST_CALC: begin
          // counts and depop id frozen so truncation alters nothing
          total_q <= total_cnt;
          ret_q   <= (total_cnt > slots) ? slots : total_cnt;
          left_q  <= (total_cnt > slots) ? slots : total_cnt;
          depop_q <= depop_id_in;
          if (!any_at_start || pages_q == {PCW{1'b0}}) begin
            abort_q <= 1'b1;
            state_q <= ST_DONE;
          end else begin
            state_q <= ST_HDR;
          end
        end
        ST_HDR, ST_DESC, ST_PAD: begin
          if (crc_fail_in) begin
            crc_q   <= 1'b1;
            state_q <= ST_DONE;
          end else if (pushing) begin
            byte_q <= byte_q + 1'b1;
            if (byte_q == last_byte) begin
              state_q <= ST_DONE;
            end else if (off == 5'h1F && state_q != ST_PAD) begin
              if (left_q != 32'h00000000 && best_found) begin
                left_q     <= left_q - 32'h00000001;
                first_q    <= 1'b0;
                last_q     <= best_id;
                cur_id_q   <= best_id;
                cur_hlth_q <= elem_health_in[8*best_idx +: 8];
                cur_rest_q <= elem_restore_in[best_idx];
                cur_cap_q  <= elem_cap_in[64*best_idx +: 64];
                cur_capk_q <= elem_cap_known_in[best_idx];
                state_q    <= ST_DESC;
              end else begin
                state_q <= ST_PAD;
              end
            end
          end
        end
        ST_DONE: begin
          done_out <= 1'b1;
          if (abort_q || crc_q) begin
            error_out[`ESRB_ERR_ABRT_BIT] <= 1'b1;
            error_out[`ESRB_ERR_ICRC_BIT] <= crc_q;
            status_out[`ESRB_STS_ERR_BIT] <= 1'b1;
            // only the aborted field case has a sense code to fetch
            status_out[`ESRB_STS_SENSE_BIT] <= abort_q;
          end
          if (abort_q) begin
            sense_key_out <= SENSE_KEY_ILLEGAL;
            asc_out       <= ASC_INVALID_FIELD;
          end
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // esrb_builder
`default_nettype wire

// File: common/esrb_defs.vh
// constants for the element status report builder
`ifndef ESRB_DEFS_VH
`define ESRB_DEFS_VH

// response geometry: lengths in bytes, page size as a shift, descriptors per page
`define ESRB_HDR_LEN        32
`define ESRB_DESC_LEN       32
`define ESRB_PAGE_SHIFT     9
`define ESRB_DESC_PER_PAGE  16

// header field byte offsets
`define ESRB_HDR_TOTAL_OFF  5'h00
`define ESRB_HDR_RET_OFF    5'h04
`define ESRB_HDR_DEPOP_OFF  5'h08

// descriptor field byte offsets
`define ESRB_DSC_ID_OFF     5'h04
`define ESRB_DSC_FLAG_OFF   5'h0D
`define ESRB_DSC_TYPE_OFF   5'h0E
`define ESRB_DSC_HLTH_OFF   5'h0F
`define ESRB_DSC_CAP_OFF    5'h10
`define ESRB_DSC_CAP_END    5'h17

// field codes
`define ESRB_TYPE_STORAGE   8'h01
`define ESRB_HLTH_NONE      8'h00
`define ESRB_HLTH_AT_LIM    8'h64
`define ESRB_HLTH_OUT_LO    8'h65
`define ESRB_HLTH_OUT_HI    8'hCF
`define ESRB_HLTH_RSV_LO    8'hD0
`define ESRB_HLTH_RSV_HI    8'hFA
`define ESRB_HLTH_REV_FAIL  8'hFB
`define ESRB_HLTH_DEP_DONE  8'hFF
`define ESRB_CAP_UNSPEC     64'hFFFFFFFFFFFFFFFF
`define ESRB_FILTER_HEALTH  2'h1

// completion register bit positions
`define ESRB_ERR_ICRC_BIT   7
`define ESRB_ERR_ABRT_BIT   2
`define ESRB_STS_SENSE_BIT  1
`define ESRB_STS_ERR_BIT    0

`endif

// File: rtl/esrb_fifo.v
// byte fifo between the report builder and the host data path
`timescale 1ns/1ps
`default_nettype none
module esrb_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8
) (
  input  wire             ref_clk_in,
  input  wire             rst_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready_out  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
  assign out_data_out  = mem_q[rd_q];
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  always @(posedge ref_clk_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // esrb_fifo
`default_nettype wire

// File: rtl/esrb_desc_byte.v
// byte formatter for one element status descriptor
`timescale 1ns/1ps
`default_nettype none
`include "esrb_defs.vh"
module esrb_desc_byte (
  input  wire [4:0]  off_in,
  input  wire [31:0] id_in,
  input  wire        restore_in,
  input  wire [7:0]  health_in,
  input  wire [63:0] cap_in,
  input  wire        cap_known_in,
  output reg  [7:0]  byte_out
);
  wire [63:0] cap;
  wire        rsv_hlth;
  wire [7:0]  hlth;
  wire [2:0]  cap_sel;
  wire [1:0]  id_sel;

  // reserved health codes are never sent; they fall back to not reported
  assign rsv_hlth = (health_in >= `ESRB_HLTH_RSV_LO) &&
                    (health_in <= `ESRB_HLTH_RSV_HI);
  assign hlth = rsv_hlth ? `ESRB_HLTH_NONE : health_in;
  assign cap  = cap_known_in ? cap_in : `ESRB_CAP_UNSPEC;
  assign cap_sel = off_in[2:0];
  assign id_sel  = off_in[1:0];

  always @* begin
    byte_out = 8'h00;
    if (off_in[4:2] == 3'h1) begin
      byte_out = id_in[8*id_sel +: 8];
    end else if (off_in == `ESRB_DSC_FLAG_OFF) begin
      // only a depopulated element may carry the restore flag
      byte_out = {7'h00, restore_in &
                  (health_in == `ESRB_HLTH_DEP_DONE)};
    end else if (off_in == `ESRB_DSC_TYPE_OFF) begin
      byte_out = `ESRB_TYPE_STORAGE;
    end else if (off_in == `ESRB_DSC_HLTH_OFF) begin
      byte_out = hlth;
    end else if (off_in >= `ESRB_DSC_CAP_OFF &&
                 off_in <= `ESRB_DSC_CAP_END) begin
      byte_out = cap[8*cap_sel +: 8];
    end
  end
endmodule // esrb_desc_byte
`default_nettype wire

// File: tb/esrb_builder_chk.sv
// concurrent checks on the report builder top ports
`timescale 1ns/1ps
`default_nettype none
module esrb_builder_chk #(
  parameter PCW = 16
) (
  input wire logic           ref_clk_in,
  input wire logic           rst_in,
  input wire logic           cmd_start_in,
  input wire logic [PCW-1:0] cmd_page_count_in,
  input wire logic           crc_fail_in,
  input wire logic [7:0]     data_out,
  input wire logic           data_valid_out,
  input wire logic           data_ready_in,
  input wire logic           busy_out,
  input wire logic           done_out,
  input wire logic [7:0]     error_out,
  input wire logic [7:0]     status_out,
  input wire logic [3:0]     sense_key_out,
  input wire logic [7:0]     asc_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // ----------------------------------------
  // byte position of the stream since start
  // ----------------------------------------
  logic [15:0] cnt_q;
  logic [7:0]  ret_q;
  logic        take;
  logic        go;
  logic        desc;
  assign take = data_valid_out && data_ready_in;
  assign go   = cmd_start_in && !busy_out;
  // only the low byte of the returned count matters, one page is 15 at most
  assign desc = cnt_q >= 16'd32 && cnt_q < 16'd32 + {3'h0, ret_q, 5'h00};
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 16'h0000;
      ret_q <= 8'h00;
    end else if (go) begin
      cnt_q <= 16'h0000;
    end else if (take) begin
      cnt_q <= cnt_q + 16'h0001;
      if (cnt_q == 16'h0004) begin
        ret_q <= data_out;
      end
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  hdr_rsv_zero_a: assert property (take && cnt_q >= 12 && cnt_q <= 31
    |-> data_out == 8'h00) else $error("header reserved byte not zero");
  pad_zero_a: assert property (take && cnt_q >= 32 && !desc
    |-> data_out == 8'h00) else $error("padding byte not zero");
  desc_rsv_a: assert property (take && desc && (cnt_q[4:0] < 5'h04 ||
    (cnt_q[4:0] >= 5'h08 && cnt_q[4:0] <= 5'h0C) || cnt_q[4:0] >= 5'h18)
    |-> data_out == 8'h00) else $error("descriptor reserved byte not zero");
  flag_bits_a: assert property (take && desc && cnt_q[4:0] == 5'h0D
    |-> data_out[7:1] == 7'h00) else $error("flag byte reserved bits set");
  type_code_a: assert property (take && desc && cnt_q[4:0] == 5'h0E
    |-> data_out == 8'h01) else $error("element type not storage");
  health_rsv_a: assert property (take && desc && cnt_q[4:0] == 5'h0F
    |-> !(data_out >= 8'hD0 && data_out <= 8'hFA))
    else $error("reserved health code sent");
  page_zero_abort_a: assert property (go && cmd_page_count_in == 0
    |-> ##3 done_out && error_out == 8'h04 && status_out == 8'h03)
    else $error("zero page count not aborted");
  sense_code_a: assert property (done_out && status_out[1]
    |-> sense_key_out == 4'h5 && asc_out == 8'h24)
    else $error("sense codes wrong");
  sense_err_a: assert property (done_out && status_out[1]
    |-> status_out[0] && error_out[2]) else $error("sense without error");
  crc_end_a: assert property (busy_out && crc_fail_in
    |-> ##[1:6] done_out && error_out == 8'h84 && status_out == 8'h01)
    else $error("crc failure not reported");
  err_hold_a: assert property (!busy_out && !cmd_start_in
    |=> $stable(error_out) && $stable(status_out))
    else $error("completion outputs changed while idle");
endmodule // esrb_builder_chk
bind esrb_builder esrb_builder_chk #(.PCW(PCW)) i_chk (.*);
`default_nettype wire

// File: tb/esrb_host_model.sv
// host side model that drains the response byte stream
`timescale 1ns/1ps
`default_nettype none
module esrb_host_model (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic       slow_in,
  input  wire logic       clr_in,
  input  wire logic [7:0] data_in,
  input  wire logic       valid_in,
  output var  logic       ready_out
);
  logic [7:0] rx_q [0:2047];
  int         n_rx;
  logic [2:0] tick_q;
  // slow mode takes one byte in eight so the fifo fills and stalls
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_q    <= 3'h0;
      ready_out <= 1'b0;
      n_rx      <= 0;
    end else begin
      tick_q    <= tick_q + 3'h1;
      ready_out <= !slow_in || tick_q == 3'h7;
      if (clr_in) begin
        n_rx <= 0;
      end else if (valid_in && ready_out && n_rx < 2048) begin
        rx_q[n_rx] <= data_in;
        n_rx       <= n_rx + 1;
      end
    end
  end
endmodule // esrb_host_model
`default_nettype wire

// File: tb/esrb_builder_bench.sv
// self-checking bench for the element status report builder
`timescale 1ns/1ps
`default_nettype none
module esrb_builder_bench;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         start = 1'b0;
  logic [1:0]   filt = 2'h0;
  logic [31:0]  st_q = 32'h0;
  logic [15:0]  pg_q = 16'h0001;
  logic [31:0]  dp_q = 32'h0;
  logic [7:0]   vld = 8'h7F;
  logic [255:0] ids;
  logic [63:0]  hlth;
  logic [7:0]   rest = 8'h4A;
  logic [511:0] caps;
  logic [7:0]   known = 8'hFB;
  logic         crc = 1'b0;
  logic         slow = 1'b0;
  logic         clr = 1'b0;
  logic [7:0]   dat;
  logic         dv;
  logic         rdy;
  logic         busy;
  logic         done;
  logic [7:0]   err;
  logic [7:0]   sts;
  logic [3:0]   skey;
  logic [7:0]   asc;
  logic [7:0]   exp_b [0:2047];
  int           n_fail = 0;
  int           checked = 0;
  always #2.5 clk = ~clk;
  esrb_builder i_dut (.ref_clk_in(clk), .rst_in(rst), .cmd_start_in(start),
    .cmd_filter_in(filt), .cmd_start_elem_in(st_q), .cmd_page_count_in(pg_q),
    .depop_id_in(dp_q), .elem_valid_in(vld), .elem_id_in(ids),
    .elem_health_in(hlth), .elem_restore_in(rest), .elem_cap_in(caps),
    .elem_cap_known_in(known), .crc_fail_in(crc), .data_out(dat),
    .data_valid_out(dv), .data_ready_in(rdy), .busy_out(busy),
    .done_out(done), .error_out(err), .status_out(sts),
    .sense_key_out(skey), .asc_out(asc));
  esrb_host_model i_host (.ref_clk_in(clk), .rst_in(rst), .slow_in(slow),
    .clr_in(clr), .data_in(dat), .valid_in(dv), .ready_out(rdy));
  // ----------------------------------------
  // closing and comparison
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    checked++;
    if (got !== want) begin
      n_fail++;
      $display("Error at %0t: got %0h expected %0h", $time, got, want);
    end
  endtask
  // ----------------------------------------
  // expected response image
  // ----------------------------------------
  task automatic put(input int at, input logic [63:0] v, input int n);
    for (int j = 0; j < n; j++) exp_b[at+j] = v[8*j+:8];
  endtask
  task automatic build(input logic [1:0] f, input logic [31:0] st,
                       input int pg, input logic [31:0] dp);
    logic [31:0] last;
    logic [31:0] best;
    logic [7:0]  h;
    int          tot;
    int          b;
    int          a;
    for (int k = 0; k < 2048; k++) exp_b[k] = 8'h00;
    tot = 0;
    last = 32'h0;
    for (int k = 0; k < 8; k++) begin
      best = 32'hFFFFFFFF;
      b = -1;
      for (int i = 0; i < 8; i++) begin
        h = hlth[8*i+:8];
        if (vld[i] && ids[32*i+:32] >= st && (k == 0 || ids[32*i+:32] > last)
            && ids[32*i+:32] <= best && (f != 2'h1 || (h >= 8'h65 &&
            h <= 8'hCF) || h >= 8'hFB)) begin
          best = ids[32*i+:32];
          b = i;
        end
      end
      if (b >= 0) begin
        last = best;
        h = hlth[8*b+:8];
        a = 32 + 32 * tot;
        if (tot < pg * 16 - 1) begin
          put(a + 4, {32'h0, best}, 4);
          exp_b[a+13] = {7'h00, rest[b] && h == 8'hFF};
          exp_b[a+14] = 8'h01;
          exp_b[a+15] = (h >= 8'hD0 && h <= 8'hFA) ? 8'h00 : h;
          put(a + 16, known[b] ? caps[64*b+:64] : 64'hFFFFFFFFFFFFFFFF, 8);
        end
        tot++;
      end
    end
    put(0, tot, 4);
    put(4, (tot < pg * 16 - 1) ? tot : pg * 16 - 1, 4);
    put(8, {32'h0, dp}, 4);
  endtask
  // ----------------------------------------
  // one command, then wait for completion and the bytes
  // ----------------------------------------
  task automatic run(input logic [1:0] f, input logic [31:0] st,
    input logic [15:0] pg, input logic [31:0] dp, input logic sl,
    input logic cf, input int want);
    int t;
    @(posedge clk);
    clr <= 1'b1;
    slow <= sl;
    filt <= f;
    st_q <= st;
    pg_q <= pg;
    dp_q <= dp;
    start <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    start <= 1'b0;
    if (cf) begin
      repeat (100) @(posedge clk);
      crc <= 1'b1;
      @(posedge clk);
      crc <= 1'b0;
    end
    t = 0;
    while (done !== 1'b1 && t < 20000) begin
      @(negedge clk);
      t++;
    end
    chk(done, 1'b1);
    t = 0;
    while (i_host.n_rx < want && t < 20000) begin
      @(negedge clk);
      t++;
    end
    repeat (30) @(negedge clk);
    $display("test done at %0t", $time);
  endtask
  task automatic cmp(input int n);
    for (int k = 0; k < n; k++) chk(i_host.rx_q[k], exp_b[k]);
  endtask
  initial begin
    for (int i = 0; i < 8; i++) begin
      ids[32*i+:32] = {28'h0, 4'(i)};
      caps[64*i+:64] = {56'h0A0B0C0D000000, 8'(i)};
    end
    ids = {32'h05, 32'h50, 32'h30, 32'h60, 32'h20, 32'h70, 32'h10, 32'h40};
    hlth = 64'hFE_FB_CF_65_64_D5_FF_01;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    build(2'h0, 32'h0, 2, 32'h123);
    run(2'h0, 32'h0, 16'd2, 32'h123, 1'b1, 1'b0, 1024);
    chk(i_host.n_rx, 1024);
    cmp(1024);
    chk({err, sts}, 16'h0000);
    build(2'h1, 32'h30, 1, 32'h0);
    run(2'h1, 32'h30, 16'd1, 32'h0, 1'b0, 1'b0, 512);
    cmp(512);
    for (int c = 0; c < 2; c++) begin
      run(2'h0, c ? 32'h0 : 32'h100, c ? 16'd0 : 16'd1, 32'h0, 1'b0, 1'b0, 0);
      chk({err, sts, skey, asc}, 28'h040_3_5_24);
      chk(i_host.n_rx, 0);
    end
    build(2'h0, 32'h0, 1, 32'h0);
    run(2'h0, 32'h0, 16'd1, 32'h0, 1'b0, 1'b1, 0);
    chk({err, sts}, 16'h8401);
    chk(i_host.n_rx < 512, 1'b1);
    cmp(i_host.n_rx);
    report_and_stop();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
endmodule // esrb_builder_bench
`default_nettype wire
